// ---- inc/pps_pkg.sv ----
// Shared constants and types for the palette priority select block
package pps_pkg;

  localparam int PPS_COMP_W = 8;
  localparam int PPS_LUT_W = 10;
  localparam int PPS_LUT_DEPTH = 256;
  localparam int PPS_FIFO_DEPTH = 4;
  // Pixel word: palette_select_bit1, palette_select_bit0, red, green, blue
  localparam int PPS_PIX_W = 3 * PPS_COMP_W + 2;
  localparam int PPS_PS0_POS = 3 * PPS_COMP_W;
  localparam int PPS_PS1_POS = 3 * PPS_COMP_W + 1;
  localparam int PPS_RED_POS = 2 * PPS_COMP_W;
  localparam int PPS_GRN_POS = PPS_COMP_W;
  localparam int PPS_BLU_POS = 0;
  localparam logic [1:0] PPS_MATCH_RST = 2'h0;
  localparam logic [PPS_LUT_W-1:0] PPS_LUT_RST = 10'h000;
  localparam int PPS_PIPE_LAT = 2;

  // Lookup write channel select, one-hot
  typedef enum logic [2:0] {
    PPS_CH_RED = 3'b001,
    PPS_CH_GRN = 3'b010,
    PPS_CH_BLU = 3'b100
  } pps_chan_t;

endpackage

// ---- rtl/pps_fifo.sv ----
// Small valid/ready FIFO carrying multiplexed pixels with select bits
`timescale 1ns/1ns
module pps_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic [AW:0] nxt_count;
  logic in_ready_ff;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // Ready comes from a flop so the pixel port has no combinational path
  assign in_ready = in_ready_ff;
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + (AW+1)'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      in_ready_ff <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      count_ff <= nxt_count;
      in_ready_ff <= (nxt_count != (AW+1)'(DEPTH));
    end
  end

  a_fifo_no_over: assert property (@(posedge clk) disable iff (!reset_n)
    count_ff <= (AW+1)'(DEPTH))
    else $error("FIFO count above depth");

  a_ready_flop: assert property (@(posedge clk) disable iff (!reset_n)
    in_ready == (count_ff != (AW+1)'(DEPTH)))
    else $error("FIFO ready disagrees with count");
endmodule

// ---- rtl/pps_top.sv ----
// Palette priority select with per-channel 8-to-10 bit lookup
//
// Overview of operation
// - Selected only when both select bits match
// - Up to four devices, distinct match codes
// - Select evaluated fresh for every pixel
// - Select bits travel with each multiplexed pixel
// - Deselected pixel drives zero output level
// - Each 8-bit component indexes 10-bit lookup
// - Red, green, blue lookups written separately
`timescale 1ns/1ns
module pps_top
  import pps_pkg::*;
#(
  parameter int COMP_W = PPS_COMP_W,
  parameter int LUT_W = PPS_LUT_W,
  parameter int FIFO_DEPTH = PPS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  // Pixel stream from the frame buffer
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [COMP_W-1:0] pix_red,
  input wire logic [COMP_W-1:0] pix_green,
  input wire logic [COMP_W-1:0] pix_blue,
  input wire logic palette_select_bit0,
  input wire logic palette_select_bit1,
  // First mode register match bits
  input wire logic match_wr,
  input wire logic match_bit0,
  input wire logic match_bit1,
  // Lookup write port
  input wire logic lut_wr,
  input wire logic [2:0] lut_chan,
  input wire logic [COMP_W-1:0] lut_addr,
  input wire logic [LUT_W-1:0] lut_data,
  // Video outputs, one per pixel cycle
  output logic out_valid_ff,
  output logic out_selected_ff,
  output logic [LUT_W-1:0] red_video_out,
  output logic [LUT_W-1:0] green_video_out,
  output logic [LUT_W-1:0] blue_video_out,
  output logic [1:0] match_code_ff
);
  localparam int PW = 3 * COMP_W + 2;
  localparam int DEPTH = 1 << COMP_W;

  logic [LUT_W-1:0] red_lut_ff [DEPTH];
  logic [LUT_W-1:0] grn_lut_ff [DEPTH];
  logic [LUT_W-1:0] blu_lut_ff [DEPTH];

  logic [PW-1:0] fifo_din;
  logic [PW-1:0] fifo_dout;
  logic fifo_valid;
  logic pop;

  // Stage 1: lookup read registers plus select decision
  logic s1_valid_ff;
  logic s1_sel_ff;
  logic [LUT_W-1:0] s1_red_ff;
  logic [LUT_W-1:0] s1_grn_ff;
  logic [LUT_W-1:0] s1_blu_ff;
  logic [LUT_W-1:0] red_out_ff;
  logic [LUT_W-1:0] grn_out_ff;
  logic [LUT_W-1:0] blu_out_ff;

  function automatic logic [COMP_W-1:0] comp_at(input logic [PW-1:0] w, input int pos);
    comp_at = w[pos +: COMP_W];
  endfunction

  // Both select bits must equal the stored match code
  function automatic logic sel_hit(input logic [PW-1:0] w, input logic [1:0] code);
    sel_hit = (w[PPS_PS1_POS] == code[1]) && (w[PPS_PS0_POS] == code[0]);
  endfunction

  // Select bits ride in the same word as their pixel through the FIFO
  assign fifo_din = {palette_select_bit1, palette_select_bit0,
                     pix_red, pix_green, pix_blue};

  pps_fifo #(
    .WIDTH(PW),
    .DEPTH(FIFO_DEPTH)
  ) pps_fifo_i (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data(fifo_din),
    .out_valid(fifo_valid),
    .out_ready(1'b1),
    .out_data(fifo_dout)
  );

  // Output side never stalls, so the FIFO only absorbs bursts
  assign pop = fifo_valid;

  // Match code register, written on every match_wr pulse
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      match_code_ff <= PPS_MATCH_RST;
    end else if (match_wr) begin
      match_code_ff <= {match_bit1, match_bit0};
    end
  end

  // Independent lookup writes per channel
  always_ff @(posedge clk) begin
    if (lut_wr && lut_chan[0]) begin
      red_lut_ff[lut_addr] <= lut_data;
    end
    if (lut_wr && lut_chan[1]) begin
      grn_lut_ff[lut_addr] <= lut_data;
    end
    if (lut_wr && lut_chan[2]) begin
      blu_lut_ff[lut_addr] <= lut_data;
    end
  end

  // Stage 1: lookup and per-pixel match, advancing together
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_valid_ff <= 1'b0;
      s1_sel_ff <= 1'b0;
      s1_red_ff <= PPS_LUT_RST;
      s1_grn_ff <= PPS_LUT_RST;
      s1_blu_ff <= PPS_LUT_RST;
    end else begin
      s1_valid_ff <= pop;
      s1_sel_ff <= pop && sel_hit(fifo_dout, match_code_ff);
      s1_red_ff <= red_lut_ff[comp_at(fifo_dout, PPS_RED_POS)];
      s1_grn_ff <= grn_lut_ff[comp_at(fifo_dout, PPS_GRN_POS)];
      s1_blu_ff <= blu_lut_ff[comp_at(fifo_dout, PPS_BLU_POS)];
    end
  end

  // Stage 2: gate outputs with the select of the same pixel
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_valid_ff <= 1'b0;
      out_selected_ff <= 1'b0;
      red_out_ff <= PPS_LUT_RST;
      grn_out_ff <= PPS_LUT_RST;
      blu_out_ff <= PPS_LUT_RST;
    end else begin
      out_valid_ff <= s1_valid_ff;
      out_selected_ff <= s1_sel_ff;
      red_out_ff <= s1_sel_ff ? s1_red_ff : PPS_LUT_RST;
      grn_out_ff <= s1_sel_ff ? s1_grn_ff : PPS_LUT_RST;
      blu_out_ff <= s1_sel_ff ? s1_blu_ff : PPS_LUT_RST;
    end
  end

  assign red_video_out = red_out_ff;
  assign green_video_out = grn_out_ff;
  assign blue_video_out = blu_out_ff;

  // Helper: one-shot sample of the select-match for assertions
  logic pop_match;
  assign pop_match = pop && sel_hit(fifo_dout, match_code_ff);

  a_sel_latency: assert property (@(posedge clk) disable iff (!reset_n)
    pop |-> ##2 (out_selected_ff == $past(pop_match, 2)))
    else $error("Select did not follow pixel by two cycles");

  a_desel_zero: assert property (@(posedge clk) disable iff (!reset_n)
    !out_selected_ff |-> (red_video_out == '0 && green_video_out == '0
                          && blue_video_out == '0))
    else $error("Deselected pixel drives non-zero output");

  a_mismatch_desel: assert property (@(posedge clk) disable iff (!reset_n)
    (pop && ({fifo_dout[PPS_PS1_POS], fifo_dout[PPS_PS0_POS]} != match_code_ff)
     && !match_wr) |-> ##2 !out_selected_ff)
    else $error("Mismatched select still enabled output");

  a_match_sel: assert property (@(posedge clk) disable iff (!reset_n)
    (pop && ({fifo_dout[PPS_PS1_POS], fifo_dout[PPS_PS0_POS]} == match_code_ff))
    |-> ##2 out_selected_ff)
    else $error("Matching pixel not selected");

  a_sel_valid: assert property (@(posedge clk) disable iff (!reset_n)
    out_selected_ff |-> out_valid_ff)
    else $error("Selected without a pixel");

  a_match_store: assert property (@(posedge clk) disable iff (!reset_n)
    match_wr |=> (match_code_ff == $past({match_bit1, match_bit0})))
    else $error("Match code not stored");

  a_lut_red: assert property (@(posedge clk) disable iff (!reset_n)
    (pop && !lut_wr) |=> (s1_red_ff == red_lut_ff[$past(fifo_dout[PPS_RED_POS +: 8])]))
    else $error("Red lookup result wrong");

  a_lut_green: assert property (@(posedge clk) disable iff (!reset_n)
    (pop && !lut_wr) |=> (s1_grn_ff == grn_lut_ff[$past(fifo_dout[PPS_GRN_POS +: COMP_W])]))
    else $error("Green lookup result wrong");

  a_lut_blue: assert property (@(posedge clk) disable iff (!reset_n)
    (pop && !lut_wr) |=> (s1_blu_ff == blu_lut_ff[$past(fifo_dout[PPS_BLU_POS +: COMP_W])]))
    else $error("Blue lookup result wrong");

  a_lut_write: assert property (@(posedge clk) disable iff (!reset_n)
    (lut_wr && lut_chan[1]) |=> (grn_lut_ff[$past(lut_addr)] == $past(lut_data)))
    else $error("Green lookup entry not written");

  a_valid_follow: assert property (@(posedge clk) disable iff (!reset_n)
    pop |-> ##2 out_valid_ff)
    else $error("Popped pixel not presented two cycles later");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    !pop |-> ##2 !out_valid_ff)
    else $error("Output valid without a popped pixel");

  a_code_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !match_wr |=> $stable(match_code_ff))
    else $error("Match code changed without a write");

  a_green_path: assert property (@(posedge clk) disable iff (!reset_n)
    (s1_sel_ff && s1_valid_ff) |=> (green_video_out == $past(s1_grn_ff)))
    else $error("Selected green value not passed out");

  a_red_path: assert property (@(posedge clk) disable iff (!reset_n)
    (s1_sel_ff && s1_valid_ff) |=> (red_video_out == $past(s1_red_ff)
                                    && blue_video_out == $past(s1_blu_ff)))
    else $error("Selected lookup value not passed out");
endmodule

// ---- verification/pps_src_model.sv ----
// Frame buffer source model: offers queued pixel words with their select pairs
`timescale 1ns/1ns
module pps_src_model
  import pps_pkg::*;
(
  input wire logic clk,
  input wire logic pix_ready,
  output logic pix_valid,
  output logic [PPS_PIX_W-1:0] pix_word
);
  logic [PPS_PIX_W-1:0] word_q [$];

  initial begin
    pix_valid = 1'b0;
    pix_word = 26'h000_0000;
  end

  task automatic push(input logic [PPS_PIX_W-1:0] w);
    word_q.push_back(w);
  endtask

  // Offer held until the edge that samples ready; select pair rides in the word
  // Idle lines toggle so a stale word can never pass for a fresh one
  always @(posedge clk) begin
    if (!pix_valid || pix_ready) begin
      if (word_q.size() > 0) begin
        pix_valid <= 1'b1;
        pix_word <= word_q.pop_front();
      end else begin
        pix_valid <= 1'b0;
        pix_word <= ~pix_word;
      end
    end
  end
endmodule

// ---- verification/test_palette_priority_select.sv ----
// Testbench for the palette priority select block
`timescale 1ns/1ns
module test_palette_priority_select;
  import pps_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic match_wr = 1'b0;
  logic match_bit0 = 1'b0;
  logic match_bit1 = 1'b0;
  logic lut_wr = 1'b0;
  logic [2:0] lut_chan = 3'h0;
  logic [7:0] lut_addr = 8'h00;
  logic [9:0] lut_data = 10'h000;
  logic pix_valid, pix_ready, out_valid_ff, out_selected_ff;
  logic [PPS_PIX_W-1:0] pix_word;
  logic [9:0] red_video_out, green_video_out, blue_video_out;
  logic [1:0] match_code_ff;
  logic [9:0] lr [16], lg [16], lb [16];
  logic [30:0] exp_q [$];
  int bad_count = 0;
  int cmp_count = 0;

  always #20 clk = ~clk;

  pps_src_model pps_src_model_i (.clk(clk), .pix_ready(pix_ready), .pix_valid(pix_valid),
    .pix_word(pix_word));

  pps_top pps_top_i (.clk(clk), .reset_n(reset_n), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_red(pix_word[PPS_RED_POS +: 8]),
    .pix_green(pix_word[PPS_GRN_POS +: 8]), .pix_blue(pix_word[PPS_BLU_POS +: 8]),
    .palette_select_bit0(pix_word[PPS_PS0_POS]), .palette_select_bit1(pix_word[PPS_PS1_POS]),
    .match_wr(match_wr), .match_bit0(match_bit0), .match_bit1(match_bit1),
    .lut_wr(lut_wr), .lut_chan(lut_chan), .lut_addr(lut_addr), .lut_data(lut_data),
    .out_valid_ff(out_valid_ff), .out_selected_ff(out_selected_ff),
    .red_video_out(red_video_out), .green_video_out(green_video_out),
    .blue_video_out(blue_video_out), .match_code_ff(match_code_ff));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Every presented pixel is judged in the cycle it stands
  always @(posedge clk) begin
    if (out_valid_ff === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'h0000_0001, 32'h0000_0000);
      end else begin
        chk({out_selected_ff, red_video_out, green_video_out, blue_video_out},
          exp_q.pop_front());
      end
    end
  end

  task automatic t_reset();
    chk(pix_ready, 1);
    chk({out_valid_ff, out_selected_ff, match_code_ff}, 0);
    chk({red_video_out, green_video_out, blue_video_out}, 0);
  endtask

  // Each channel written on its own with its own curve
  task automatic t_lut();
    for (int a = 0; a < 16; a++) begin
      lr[a] = 10'(a * 37 + 3);
      lg[a] = 10'(1000 - a * 11);
      lb[a] = 10'(a * 64 + 5);
      for (int c = 0; c < 3; c++) begin
        @(posedge clk);
        lut_wr <= 1'b1;
        lut_chan <= 3'(1 << c);
        lut_addr <= 8'(a);
        lut_data <= (c == 0) ? lr[a] : (c == 1) ? lg[a] : lb[a];
      end
    end
    @(posedge clk);
    lut_wr <= 1'b0;
  endtask

  // Back-to-back pixels whose select pair changes on every pixel
  task automatic t_stream(input logic [1:0] code);
    logic [PPS_PIX_W-1:0] w;
    @(posedge clk);
    match_wr <= 1'b1;
    match_bit0 <= code[0];
    match_bit1 <= code[1];
    @(posedge clk);
    match_wr <= 1'b0;
    @(posedge clk);
    chk(match_code_ff, code);
    for (int i = 0; i < 16; i++) begin
      w = {2'(i), 8'(i), 8'((i + 5) % 16), 8'(15 - i)};
      if (2'(i) == code) begin
        exp_q.push_back({1'b1, lr[i], lg[(i + 5) % 16], lb[15 - i]});
      end else begin
        exp_q.push_back(31'h0000_0000);
      end
      pps_src_model_i.push(w);
    end
    for (int k = 0; k < 100 && exp_q.size() > 0; k++) begin
      @(posedge clk);
    end
    chk(exp_q.size(), 0);
  endtask

  initial begin
    #(40 * 5000);
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_lut();
    for (int c = 0; c < 4; c++) begin
      t_stream(2'(c));
    end
    report_and_stop();
  end
endmodule
